// >>> dv/core_model.sv
// core model: follows the halt request and finishes register transfers after a set delay
`default_nettype none
module core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic halt_req,
  input wire logic xfer_req,
  input wire logic [3:0] dly,
  output logic core_halted,
  output logic xfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  // halt request enters or leaves debug state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) core_halted <= 1'h0;
    else core_halted <= halt_req;
  end
  // one done pulse per request, delay chosen by the bench
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
      xfer_done <= 1'h0;
    end else begin
      xfer_done <= 1'h0;
      if (!xfer_req || xfer_done) wait_reg <= 4'h0;
      else if (wait_reg == dly) xfer_done <= 1'h1;
      else wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> dv/halting_debug_control_test.sv
// self-checking bench for the halting debug control block
`default_nettype none
module halting_debug_control_test;
  import halting_debug_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, acc_valid, acc_write, acc_from_dap, acc_ack, core_halted, halt_req, step_en, debug_en;
  logic pend_sv_in, system_tick_interrupt_in, nmi_in, pend_sv_out, system_tick_interrupt_out, nmi_out, xfer_req, xfer_write, xfer_done;
  logic [1:0] acc_addr;
  logic [31:0] acc_wdata, acc_rdata, ext_irq_in, ext_irq_out, rd, sel_word, sel_exp;
  logic [SEL_W-1:0] xfer_sel;
  logic [3:0] dly;
  int err_total, total_checks, cyc;
  halting_debug_control halting_debug_control_inst (.mclk(mclk), .rst_n(rst_n), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_from_dap(acc_from_dap), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_ack(acc_ack), .core_halted(core_halted), .halt_req(halt_req), .step_en(step_en),
    .debug_en(debug_en), .pend_sv_in(pend_sv_in), .system_tick_interrupt_in(system_tick_interrupt_in), .ext_irq_in(ext_irq_in),
    .nmi_in(nmi_in), .pend_sv_out(pend_sv_out), .system_tick_interrupt_out(system_tick_interrupt_out), .ext_irq_out(ext_irq_out),
    .nmi_out(nmi_out), .xfer_req(xfer_req), .xfer_sel(xfer_sel), .xfer_write(xfer_write), .xfer_done(xfer_done));
  core_model core_model_inst (.mclk(mclk), .rst_n(rst_n), .halt_req(halt_req), .xfer_req(xfer_req),
    .dly(dly), .core_halted(core_halted), .xfer_done(xfer_done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one access: request held for one edge, ack looked at in the cycle after
  task automatic acc(input logic w, input logic d, input logic [1:0] a, input logic [31:0] wd);
    @(posedge mclk);
    acc_valid <= 1'h1;
    acc_write <= w;
    acc_from_dap <= d;
    acc_addr <= a;
    acc_wdata <= wd;
    @(posedge mclk);
    acc_valid <= 1'h0;
    #1;
    chk(32'(acc_ack), 32'h0000_0001);
    rd = acc_rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {acc_valid, acc_write, acc_from_dap, pend_sv_in, system_tick_interrupt_in, nmi_in} = 6'h00;
    acc_addr = 2'h0;
    acc_wdata = 32'h0000_0000;
    ext_irq_in = 32'h0000_0000;
    dly = 4'h4;
    rst_n = 1'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
    chk(rd, 32'h0001_0000);
    acc(1'h1, 1'h0, ADDR_CTRL_STATUS, 32'h0000_0001);
    acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
    chk(rd, 32'h0001_0000);
    $display("reset and software write test done");
    // the enabling write keeps the mask bit at 0
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_0001);
    wt(1);
    chk(32'(debug_en), 32'h0000_0001);
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_0003);
    acc(1'h1, 1'h0, ADDR_CTRL_STATUS, 32'h0000_0002);
    acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
    chk(rd, 32'h0003_0003);
    $display("enable and halt test done");
    {pend_sv_in, system_tick_interrupt_in, nmi_in} <= 3'h7;
    ext_irq_in <= 32'hFFFF_FFFF;
    // mask is only changed while halt already reads 1 and is written 1 again
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_000B);
    wt(2);
    chk({pend_sv_out, system_tick_interrupt_out, nmi_out, ext_irq_out[0]}, 32'h0000_0002);
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_0007);
    wt(2);
    chk({step_en, pend_sv_out, system_tick_interrupt_out, ext_irq_out[31]}, 32'h0000_000F);
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_0003);
    wt(1);
    chk(32'(step_en), 32'h0000_0000);
    $display("mask and step test done");
    for (int i = 0; i < 3; i++) begin
      dly <= 4'(4 + i);
      sel_word = (i == 0) ? 32'h0001_0014 : (i == 1) ? 32'h0000_0000 : 32'h0001_000C;
      sel_exp = (i == 0) ? 32'h0000_0314 : (i == 1) ? 32'h0000_0200 : 32'h0000_030C;
      acc(1'h1, 1'h1, ADDR_CORE_SEL, sel_word);
      chk({xfer_req, xfer_write, 3'h0, xfer_sel}, sel_exp);
      // a second selector write while the first is pending must not disturb it
      acc(1'h1, 1'h1, ADDR_CORE_SEL, 32'h0000_0001);
      chk({xfer_req, xfer_write, 3'h0, xfer_sel}, sel_exp);
      acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
      chk(rd, 32'h0002_0003);
      for (int k = 0; k < 20 && xfer_req; k++) wt(1);
      acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
      chk(rd, 32'h0003_0003);
    end
    $display("core transfer test done");
    acc(1'h1, 1'h1, ADDR_CTRL_STATUS, 32'h0000_0001);
    wt(2);
    chk({halt_req, core_halted}, 32'h0000_0000);
    acc(1'h1, 1'h1, ADDR_CORE_SEL, 32'h0001_0003);
    chk(32'(xfer_req), 32'h0000_0000);
    acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
    chk(rd, 32'h0001_0001);
    acc(1'h0, 1'h1, 2'h2, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("resume and refusal test done");
    // a second reset in mid-run must drop the debug enable again
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    acc(1'h0, 1'h1, ADDR_CTRL_STATUS, 32'h0);
    chk(rd, 32'h0001_0000);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> shared/halting_debug_pkg.sv
// constants and types shared by the halting debug control block
`default_nettype none
package halting_debug_pkg;
  // register index on the access port
  localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CORE_SEL = 2'h1;
  // control/status field positions
  localparam int DEBUGEN_BIT = 0;
  localparam int HALT_BIT = 1;
  localparam int STEP_BIT = 2;
  localparam int MASK_BIT = 3;
  localparam int READY_BIT = 16;
  localparam int HALTED_BIT = 17;
  // selector field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int DIR_BIT = 16;
  // reset values
  localparam logic RESET_DEBUGEN = 1'b0;
  localparam logic RESET_CTRL = 1'b0;
  localparam logic RESET_READY = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic {XFER_IDLE, XFER_WAIT} xfer_state_t;
endpackage
`default_nettype wire

// >>> src/core_xfer_engine.sv
// core register transfer sequencer: holds one request until the core completes it
`default_nettype none
module core_xfer_engine
  import halting_debug_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [SEL_W-1:0] sel,
  input wire logic write_dir,
  input wire logic xfer_done,
  output logic xfer_req,
  output logic [SEL_W-1:0] xfer_sel,
  output logic xfer_write
);
  xfer_state_t state_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= XFER_IDLE;
    end else begin
      unique case (state_reg)
        XFER_IDLE: begin
          if (start) begin
            state_reg <= XFER_WAIT;
          end
        end
        XFER_WAIT: begin
          if (xfer_done) begin
            state_reg <= XFER_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_req <= 1'b0;
    end else if (state_reg == XFER_IDLE) begin
      xfer_req <= start;
    end else if (xfer_done) begin
      xfer_req <= 1'b0;
    end
  end

  // target and direction are captured with the start so they stay put while the core works
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_sel <= '0;
      xfer_write <= 1'b0;
    end else if (start && state_reg == XFER_IDLE) begin
      xfer_sel <= sel;
      xfer_write <= write_dir;
    end
  end
endmodule
`default_nettype wire

// >>> src/halting_debug_control.sv
// halting debug control/status bits, core register selector and interrupt masking
`default_nettype none
module halting_debug_control
  import halting_debug_pkg::*;
#(
  parameter int EXT_IRQ_W = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_from_dap,
  input wire logic [1:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic [31:0] acc_rdata,
  output logic acc_ack,
  input wire logic core_halted,
  output logic halt_req,
  output logic step_en,
  output logic debug_en,
  input wire logic pend_sv_in,
  input wire logic system_tick_interrupt_in,
  input wire logic [EXT_IRQ_W-1:0] ext_irq_in,
  input wire logic nmi_in,
  output logic pend_sv_out,
  output logic system_tick_interrupt_out,
  output logic [EXT_IRQ_W-1:0] ext_irq_out,
  output logic nmi_out,
  output logic xfer_req,
  output logic [SEL_W-1:0] xfer_sel,
  output logic xfer_write,
  input wire logic xfer_done
);
  logic debug_en_reg;
  logic halt_reg;
  logic step_reg;
  logic mask_reg;
  logic ready_reg;
  logic ctrl_wr;
  logic sel_wr;
  logic xfer_start;
  logic mask_active;

  function automatic logic reg_hit(input logic [1:0] addr, input logic [1:0] code);
    reg_hit = (addr == code);
  endfunction

  assign ctrl_wr = acc_valid && acc_write && reg_hit(acc_addr, ADDR_CTRL_STATUS);
  assign sel_wr = acc_valid && acc_write && reg_hit(acc_addr, ADDR_CORE_SEL);
  // debug state only
  // a second selector write while a transfer is still pending is dropped, so the core sees one request at a time
  assign xfer_start = sel_wr && core_halted && !xfer_req;
  assign mask_active = mask_reg && debug_en_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debug_en_reg <= RESET_DEBUGEN;
    end else if (ctrl_wr && acc_from_dap) begin
      debug_en_reg <= acc_wdata[DEBUGEN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halt_reg <= RESET_CTRL;
      step_reg <= RESET_CTRL;
      mask_reg <= RESET_CTRL;
    end else if (ctrl_wr) begin
      halt_reg <= acc_wdata[HALT_BIT];
      step_reg <= acc_wdata[STEP_BIT];
      // mask change is only meaningful while halted; other cases are left to the debugger to avoid
      mask_reg <= acc_wdata[MASK_BIT];
    end
  end

  // halt and step only act with debug enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halt_req <= 1'b0;
      step_en <= 1'b0;
      debug_en <= 1'b0;
    end else begin
      halt_req <= halt_reg && debug_en_reg;
      step_en <= step_reg && debug_en_reg;
      debug_en <= debug_en_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_sv_out <= 1'b0;
      system_tick_interrupt_out <= 1'b0;
      ext_irq_out <= '0;
      nmi_out <= 1'b0;
    end else begin
      pend_sv_out <= pend_sv_in && !mask_active;
      system_tick_interrupt_out <= system_tick_interrupt_in && !mask_active;
      ext_irq_out <= ext_irq_in & {EXT_IRQ_W{!mask_active}};
      nmi_out <= nmi_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= RESET_READY;
    end else if (xfer_start) begin
      ready_reg <= 1'b0;
    end else if (xfer_req && xfer_done) begin
      ready_reg <= 1'b1;
    end
  end

  core_xfer_engine core_xfer_engine_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(xfer_start),
    .sel(acc_wdata[SEL_LSB +: SEL_W]),
    .write_dir(acc_wdata[DIR_BIT]),
    .xfer_done(xfer_done),
    .xfer_req(xfer_req),
    .xfer_sel(xfer_sel),
    .xfer_write(xfer_write)
  );

  // mask read returns stored value, undefined by contract when disabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata <= ZERO_WORD;
      acc_ack <= 1'b0;
    end else begin
      acc_ack <= acc_valid;
      if (acc_valid && !acc_write && reg_hit(acc_addr, ADDR_CTRL_STATUS)) begin
        acc_rdata <= ZERO_WORD;
        acc_rdata[DEBUGEN_BIT] <= debug_en_reg;
        acc_rdata[HALT_BIT] <= halt_reg;
        acc_rdata[STEP_BIT] <= step_reg;
        acc_rdata[MASK_BIT] <= mask_reg;
        acc_rdata[READY_BIT] <= ready_reg;
        acc_rdata[HALTED_BIT] <= core_halted;
      end else if (acc_valid) begin
        // selector is write-only; it and unmapped addresses read zero
        acc_rdata <= ZERO_WORD;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence dap_ctrl_write;
    acc_valid && acc_write && acc_addr == ADDR_CTRL_STATUS && acc_from_dap;
  endsequence
  sequence sel_write_ok;
    acc_valid && acc_write && acc_addr == ADDR_CORE_SEL && core_halted && !xfer_req;
  endsequence
  sequence ctrl_read;
    acc_valid && !acc_write && acc_addr == ADDR_CTRL_STATUS;
  endsequence

  // reset disables every check, so release edges are never judged against stale history
  debugen_dap_a: assert property (dap_ctrl_write |=> debug_en_reg == $past(acc_wdata[DEBUGEN_BIT]))
    else $error("debug enable not taken from port write");
  debugen_sw_a: assert property (ctrl_wr && !acc_from_dap |=> $stable(debug_en_reg))
    else $error("software changed debug enable");
  halt_req_a: assert property (ctrl_wr |=> ##1 halt_req ==
    ($past(acc_wdata[HALT_BIT], 2) && $past(debug_en_reg)))
    else $error("halt request does not follow write");
  step_en_a: assert property (ctrl_wr |=> ##1 step_en ==
    ($past(acc_wdata[STEP_BIT], 2) && $past(debug_en_reg)))
    else $error("step enable does not follow write");
  mask_block_a: assert property (mask_active |=> !pend_sv_out && !system_tick_interrupt_out && ext_irq_out == '0)
    else $error("masked interrupt delivered");
  unmask_pass_a: assert property (!mask_active |=> pend_sv_out == $past(pend_sv_in)
    && system_tick_interrupt_out == $past(system_tick_interrupt_in) && ext_irq_out == $past(ext_irq_in))
    else $error("unmasked interrupt not passed");
  nmi_pass_a: assert property (nmi_in |=> nmi_out)
    else $error("nmi blocked");
  nmi_quiet_a: assert property (!nmi_in |=> !nmi_out)
    else $error("nmi raised without request");
  gate_off_a: assert property (!debug_en_reg |=> !halt_req && !step_en)
    else $error("halt or step active with debug disabled");
  sel_start_a: assert property (sel_write_ok ##1 1'b1 |-> xfer_req && !ready_reg
    && xfer_sel == $past(acc_wdata[SEL_LSB +: SEL_W]) && xfer_write == $past(acc_wdata[DIR_BIT]))
    else $error("selector write did not start transfer");
  sel_ignore_a: assert property (sel_wr && !core_halted && !xfer_req |=> !xfer_req && $stable(ready_reg))
    else $error("selector write outside debug state acted");
  sel_busy_a: assert property (sel_wr && xfer_req && !xfer_done |=> xfer_req
    && $stable(xfer_sel) && $stable(ready_reg))
    else $error("selector write during transfer acted");
  ready_set_a: assert property (xfer_req && xfer_done |=> ready_reg && !xfer_req)
    else $error("ready flag not set on completion");
  status_read_a: assert property (ctrl_read |=> acc_rdata[READY_BIT] == $past(ready_reg)
    && acc_rdata[HALTED_BIT] == $past(core_halted))
    else $error("status read shows wrong ready or halted");
endmodule
`default_nettype wire
